// *** sinc_pkg.sv ***
package sinc_pkg;

  // ==========================================================================
  // Decimation ratios and sizing
  localparam int unsigned STAGE1_RATIO = 24;
  localparam int unsigned STAGE2_RATIO = 4;
  localparam int unsigned SINC_ORDER = 3;
  localparam int unsigned MOD_DELAY_SAMPLES = 2;

  // ==========================================================================
  // Modulator sample timing: 1 MHz bit rate at a 40 MHz system clock
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned MOD_RATE_HZ = 1_000_000;
  localparam int unsigned MOD_TICK_CYCLES = SYS_CLK_HZ / MOD_RATE_HZ;

  // ==========================================================================
  // Word widths: stage 1 growth 3*log2(24) -> 14 bits plus sign, stage 2 adds 6
  localparam int unsigned S1_ACC_W = 16;
  localparam int unsigned S2_ACC_W = 22;
  localparam int unsigned OUT_W = 16;
  localparam int unsigned COEF_W = 16;
  localparam int unsigned FRAC_W = 14;
  localparam int unsigned TEMP_W = 12;

  // Reset values
  localparam logic [OUT_W-1:0] OUT_RESET = 16'h0000;

  typedef struct packed {
    logic signed [COEF_W-1:0] offset;
    logic signed [COEF_W-1:0] offset_tc;
    logic signed [COEF_W-1:0] gain;
    logic signed [COEF_W-1:0] gain_tc;
    logic signed [COEF_W-1:0] square;
  } trim_coef_type;

  typedef struct packed {
    logic valid;
    logic signed [OUT_W-1:0] data;
  } sample_type;

endpackage

// *** sinc_stage.sv ***
`timescale 1ns/10ps
module sinc_stage
  import sinc_pkg::*;
#(
  parameter int unsigned IN_W = 2,
  parameter int unsigned ACC_W = 16,
  parameter int unsigned RATIO = 24,
  parameter int unsigned SHIFT_W = 14
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic signed [IN_W-1:0] in_data_i,
  output logic out_valid_o,
  output logic signed [ACC_W-1:0] out_data_o
);

  // ==========================================================================
  // Integrators at input rate; wrap-around is harmless in modular arithmetic
  logic signed [ACC_W-1:0] integ_q [SINC_ORDER];
  logic signed [ACC_W-1:0] comb_q [SINC_ORDER];
  logic signed [ACC_W-1:0] comb_in [SINC_ORDER+1];
  logic [$clog2(RATIO)-1:0] phase_q;
  logic dump;

  assign dump = in_valid_i && (phase_q == ($clog2(RATIO))'(RATIO - 1));

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < SINC_ORDER; i++) begin
        integ_q[i] <= '0;
      end
    end else if (ce_i && in_valid_i) begin
      integ_q[0] <= integ_q[0] + ACC_W'(in_data_i);
      for (int i = 1; i < SINC_ORDER; i++) begin
        integ_q[i] <= integ_q[i] + integ_q[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= '0;
    end else if (ce_i && in_valid_i) begin
      phase_q <= dump ? '0 : phase_q + 1'b1;
    end
  end

  // ==========================================================================
  // Differentiators at output rate
  assign comb_in[0] = integ_q[SINC_ORDER-1];
  generate
    for (genvar k = 0; k < SINC_ORDER; k++) begin : g_comb
      assign comb_in[k+1] = comb_in[k] - comb_q[k];
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < SINC_ORDER; i++) begin
        comb_q[i] <= '0;
      end
      out_data_o <= '0;
      out_valid_o <= 1'b0;
    end else if (ce_i) begin
      out_valid_o <= dump;
      if (dump) begin
        for (int i = 0; i < SINC_ORDER; i++) begin
          comb_q[i] <= comb_in[i];
        end
        out_data_o <= comb_in[SINC_ORDER];
      end
    end
  end

endmodule

// *** sinc_decimator.sv ***
`timescale 1ns/10ps
// Operation
// - First third-order sinc decimator emits one word per 24 bits.
// - Second third-order sinc decimator emits one word per 4 words.
// - Stages do not scale; one final multiply by 2^15 / (24^3 * 4^3) gives unity DC gain, parallel word.
// - Modulator path is a two-sample pure delay with constant gain.
// - Digital trim corrects offset and sensitivity over temperature, and nonlinearity with a fixed square term.
// - Decimated word goes onward to the downstream IIR low-pass filter; no IIR filter is built here, sinc_o and trim_o are the final outputs.
module sinc_decimator
  import sinc_pkg::*;
#(
  parameter int unsigned RATIO1 = STAGE1_RATIO,
  parameter int unsigned RATIO2 = STAGE2_RATIO
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic mod_bit_i,
  input wire trim_coef_type trim_i,
  input wire logic signed [TEMP_W-1:0] temp_i,
  output sample_type sinc_o,
  output sample_type trim_o
);

  // ==========================================================================
  // Pin synchroniser: third and second flop must agree before a change counts
  logic [2:0] bit_sync_q;
  logic bit_q;
  logic [$clog2(MOD_TICK_CYCLES)-1:0] tick_cnt_q;
  logic tick;
  logic [MOD_DELAY_SAMPLES-1:0] delay_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_sync_q <= 3'b000;
      bit_q <= 1'b0;
    end else if (ce_i) begin
      bit_sync_q <= {bit_sync_q[1:0], mod_bit_i};
      if (bit_sync_q[2] == bit_sync_q[1]) begin
        bit_q <= bit_sync_q[2];
      end
    end
  end

  // Local 1 MHz sample strobe; the modulator is assumed locked to it
  assign tick = (tick_cnt_q == ($clog2(MOD_TICK_CYCLES))'(MOD_TICK_CYCLES - 1));

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
    end else if (ce_i) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Two-sample delay line, no other shaping of the stream
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      delay_q <= '0;
    end else if (ce_i && tick) begin
      delay_q <= {delay_q[MOD_DELAY_SAMPLES-2:0], bit_q};
    end
  end

  // Bit 1 -> +1, bit 0 -> -1
  logic signed [1:0] bipolar;
  assign bipolar = delay_q[MOD_DELAY_SAMPLES-1] ? 2'sb01 : 2'sb11;

  // ==========================================================================
  // Two cascaded sinc3 stages
  logic s1_valid;
  logic signed [S1_ACC_W-1:0] s1_data;
  logic s2_valid;
  logic signed [S2_ACC_W-1:0] s2_data;
  logic signed [S2_ACC_W-1:0] s1_scaled;
  logic s1_valid_q;
  logic signed [S2_ACC_W-1:0] s1_word_q;

  sinc_stage #(
    .IN_W(2),
    .ACC_W(S1_ACC_W),
    .RATIO(RATIO1),
    .SHIFT_W(0)
  ) u_stage1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(tick),
    .in_data_i(bipolar),
    .out_valid_o(s1_valid),
    .out_data_o(s1_data)
  );

  // Stage 1 word keeps its full 14-bit fraction; division by 24^3 is folded
  // into the final normalisation so no precision is lost between stages
  assign s1_scaled = S2_ACC_W'(s1_data);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_valid_q <= 1'b0;
      s1_word_q <= '0;
    end else if (ce_i) begin
      s1_valid_q <= s1_valid;
      if (s1_valid) begin
        s1_word_q <= s1_scaled;
      end
    end
  end

  sinc_stage #(
    .IN_W(S2_ACC_W),
    .ACC_W(S2_ACC_W),
    .RATIO(RATIO2),
    .SHIFT_W(0)
  ) u_stage2 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(s1_valid_q),
    .in_data_i(s1_word_q),
    .out_valid_o(s2_valid),
    .out_data_o(s2_data)
  );

  // ==========================================================================
  // Unity DC gain: multiply by 2^15 / (24^3 * 4^3) in fixed point
  localparam int unsigned GAIN_DIV = (STAGE1_RATIO ** 3) * (STAGE2_RATIO ** 3);
  localparam int unsigned NORM_SHIFT = 24;
  localparam logic [23:0] NORM_MUL = 24'((64'(1) << (NORM_SHIFT + OUT_W - 1)) / GAIN_DIV);
  logic signed [S2_ACC_W+24:0] norm_prod;
  logic signed [S2_ACC_W+24:0] norm_shift;

  assign norm_prod = $signed(s2_data) * $signed({1'b0, NORM_MUL});
  assign norm_shift = norm_prod >>> NORM_SHIFT;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sinc_o <= '{valid: 1'b0, data: OUT_RESET};
    end else if (ce_i) begin
      sinc_o.valid <= s2_valid;
      if (s2_valid) begin
        sinc_o.data <= sat16(norm_shift);
      end
    end
  end

  function automatic logic signed [OUT_W-1:0] sat16(input logic signed [S2_ACC_W+24:0] v);
    if (v > (S2_ACC_W+25)'(32767)) begin
      sat16 = 16'sh7fff;
    end else if (v < -(S2_ACC_W+25)'(32768)) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[OUT_W-1:0];
    end
  endfunction

  // ==========================================================================
  // Trim: y = (x + off(T)) * gain(T) + square * x^2, gain and square coefficients in Q2.14, offset coefficients in output LSBs
  logic signed [COEF_W:0] off_t;
  logic signed [COEF_W:0] gain_t;
  logic signed [COEF_W+TEMP_W-1:0] off_tc_prod;
  logic signed [COEF_W+TEMP_W-1:0] gain_tc_prod;
  logic signed [OUT_W+1:0] x_off;
  logic signed [2*OUT_W-1:0] x_sq;
  logic signed [OUT_W+COEF_W+2:0] lin_prod;
  logic signed [2*OUT_W+COEF_W-1:0] sq_prod;
  logic signed [S2_ACC_W+24:0] trim_sum;
  logic trim_valid_q;

  assign off_tc_prod = trim_i.offset_tc * temp_i;
  assign gain_tc_prod = trim_i.gain_tc * temp_i;
  assign off_t = (COEF_W+1)'(trim_i.offset) + (COEF_W+1)'(off_tc_prod >>> TEMP_W);
  assign gain_t = (COEF_W+1)'(trim_i.gain) + (COEF_W+1)'(gain_tc_prod >>> TEMP_W);
  assign x_off = (OUT_W+2)'(sinc_o.data) + (OUT_W+2)'(off_t);
  assign x_sq = sinc_o.data * sinc_o.data;
  assign lin_prod = x_off * gain_t;
  assign sq_prod = (x_sq >>> (OUT_W - 1)) * trim_i.square;
  assign trim_sum = (S2_ACC_W+25)'(lin_prod >>> FRAC_W)
                  + (S2_ACC_W+25)'(sq_prod >>> FRAC_W);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trim_valid_q <= 1'b0;
      trim_o <= '{valid: 1'b0, data: OUT_RESET};
    end else if (ce_i) begin
      trim_valid_q <= s2_valid;
      trim_o.valid <= trim_valid_q;
      if (trim_valid_q) begin
        trim_o.data <= sat16(trim_sum);
      end
    end
  end

endmodule

// *** mod_source.sv ***
`timescale 1ns/10ps
module mod_source
  import sinc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  output logic bit_o
);
  // ====
  // Pacing: own divider, phase unrelated to the device tick
  logic [5:0] div_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 6'h05;
    end else if (div_q == 6'h00) begin
      div_q <= 6'(MOD_TICK_CYCLES - 1);
    end else begin
      div_q <= div_q - 6'h01;
    end
  end
  // Mode 0 zeros, 1 ones, 2 alternating
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_o <= 1'b0;
    end else if (div_q == 6'h00) begin
      bit_o <= (mode_i == 2'h2) ? ~bit_o : mode_i[0];
    end
  end
endmodule

// *** sinc_decimator_asserts.sv ***
`timescale 1ns/10ps
module sinc_decimator_asserts
  import sinc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic mod_bit_i,
  input wire sample_type sinc_o,
  input wire sample_type trim_o
);
  // ====
  // Helpers
  // Seven words: six of transient plus one clean
  localparam int unsigned SETTLE = 7 * MOD_TICK_CYCLES * STAGE1_RATIO * STAGE2_RATIO;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [11:0] gap_q;
  logic seen_q;
  logic [15:0] run_q;
  logic last_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 12'h000;
      seen_q <= 1'b0;
    end else if (sinc_o.valid) begin
      gap_q <= 12'h000;
      seen_q <= 1'b1;
    end else if (ce_i) begin
      gap_q <= gap_q + 12'h001;
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 16'h0000;
      last_q <= 1'b0;
    end else begin
      last_q <= mod_bit_i;
      run_q <= (mod_bit_i != last_q) ? 16'h0000 : run_q + 16'(run_q != 16'hFFFF);
    end
  end
  // ====
  // Properties
  chk_word_period: assert property (sinc_o.valid && seen_q |-> gap_q == 12'hEFF)
    else $error("sinc output spacing is not 3840 cycles");
  chk_valid_pulse: assert property (sinc_o.valid |=> !sinc_o.valid [*8])
    else $error("sinc valid longer than one cycle");
  chk_sinc_hold: assert property (!sinc_o.valid |-> $stable(sinc_o.data))
    else $error("sinc data moved without valid");
  chk_trim_follows: assert property (sinc_o.valid |=> trim_o.valid)
    else $error("trim valid missing after sinc valid");
  chk_trim_cause: assert property (trim_o.valid |-> $past(sinc_o.valid))
    else $error("trim valid without sinc valid");
  chk_trim_hold: assert property (!trim_o.valid |-> $stable(trim_o.data))
    else $error("trim data moved without valid");
  chk_full_high: assert property (sinc_o.valid && mod_bit_i && run_q > SETTLE
    |-> sinc_o.data == 16'h7FFF)
    else $error("full scale high not 7fff");
  chk_full_low: assert property (sinc_o.valid && !mod_bit_i && run_q > SETTLE
    |-> sinc_o.data == 16'h8000)
    else $error("full scale low not 8000");
  cov_word: cover property (sinc_o.valid && seen_q);
  cov_high: cover property (sinc_o.valid && mod_bit_i && run_q > SETTLE);
  cov_low: cover property (sinc_o.valid && !mod_bit_i && run_q > SETTLE);
endmodule
bind sinc_decimator sinc_decimator_asserts u_asserts (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .mod_bit_i(mod_bit_i), .sinc_o(sinc_o), .trim_o(trim_o));

// *** sigma_delta_sinc_decimator_tb.sv ***
`timescale 1ns/10ps
module sigma_delta_sinc_decimator_tb;
  import sinc_pkg::*;
  localparam int unsigned PERIOD = MOD_TICK_CYCLES * STAGE1_RATIO * STAGE2_RATIO;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b0;
  logic [1:0] mode = 2'h1;
  logic mod_bit;
  trim_coef_type trim = '0;
  logic signed [TEMP_W-1:0] temp = '0;
  sample_type sinc;
  sample_type trimmed;
  int fails = 0;
  int total_checks = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  mod_source src (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mode_i(mode), .bit_o(mod_bit));
  sinc_decimator uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .mod_bit_i(mod_bit),
    .trim_i(trim), .temp_i(temp), .sinc_o(sinc), .trim_o(trimmed));
  // ====
  // Shared tasks
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_words(input int n);
    int left;
    repeat (n) begin
      left = PERIOD + 400;
      do begin
        @(posedge sys_clk_i);
        #1;
        left--;
      end while (sinc.valid !== 1'b1 && left > 0);
      check_word("sinc_o.valid", 16'h0001, {15'h0000, sinc.valid});
    end
    @(posedge sys_clk_i);
    #1;
    check_word("trim_o.valid", 16'h0001, {15'h0000, trimmed.valid});
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic test_high();
    wait_words(7);
    check_word("sinc_o.data", 16'h7FFF, sinc.data);
    check_word("trim_o.data", 16'h7FFF, trimmed.data);
    @(posedge sys_clk_i);
    trim.gain <= 16'h2000;
    wait_words(1);
    check_word("trim_o.data", 16'h3FFF, trimmed.data);
    $display("test high done");
  endtask
  task automatic test_low();
    @(posedge sys_clk_i);
    mode <= 2'h0;
    trim.gain <= 16'h4000;
    trim.offset <= 16'h0010;
    wait_words(7);
    check_word("sinc_o.data", 16'h8000, sinc.data);
    check_word("trim_o.data", 16'h8010, trimmed.data);
    @(posedge sys_clk_i);
    trim.offset <= 16'h0000;
    trim.offset_tc <= 16'h1000;
    temp <= 12'h400;
    wait_words(1);
    check_word("trim_o.data", 16'h8400, trimmed.data);
    // Gain drift of -1/4 at T/4096 = 1/4 plus a square term of 1/8 full scale
    @(posedge sys_clk_i);
    trim.offset_tc <= 16'h0000;
    trim.gain_tc <= 16'hC000;
    trim.square <= 16'h0800;
    wait_words(1);
    check_word("trim_o.data", 16'hB000, trimmed.data);
    $display("test low done");
  endtask
  task automatic test_alternate();
    @(posedge sys_clk_i);
    mode <= 2'h2;
    trim.offset_tc <= 16'h0000;
    repeat (900) @(posedge sys_clk_i);
    ce_i <= 1'b0;
    repeat (200) @(posedge sys_clk_i);
    ce_i <= 1'b1;
    wait_words(6);
    // Alternating stream settles to zero within a few counts
    check_word("sinc_o.data hi", sinc.data[15] ? 16'h00FF : 16'h0000, {8'h00, sinc.data[15:8]});
    $display("test alternate done");
  endtask
  initial begin
    trim.gain = 16'h4000;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    ce_i <= 1'b1;
    test_high();
    test_low();
    test_alternate();
    summarize();
  end
  initial begin
    repeat (25 * PERIOD) @(posedge sys_clk_i);
    fails++;
    $display("wrong value run time: expected end, seen hang");
    summarize();
  end
endmodule
